// [pkg/pcrm_pkg.sv]
// shared types of the pmic control register bank
package pcrm_pkg;

  typedef logic [7:0] pcrm_byte_t;
  typedef logic [3:0] pcrm_bitcnt_t;

  // serial byte engine states
  typedef enum logic [8:0]
  {
    PCRM_ST_IDLE = 9'h001,
    PCRM_ST_ADDR = 9'h002,
    PCRM_ST_ADDR_ACK = 9'h004,
    PCRM_ST_REG = 9'h008,
    PCRM_ST_REG_ACK = 9'h010,
    PCRM_ST_WDATA = 9'h020,
    PCRM_ST_WDATA_ACK = 9'h040,
    PCRM_ST_RDATA = 9'h080,
    PCRM_ST_RDATA_ACK = 9'h100
  } pcrm_state_e;

endpackage

// [pkg/pcrm_regs.svh]
// register offsets, field positions and reset values of the pmic control register bank
// Function
// - ctrl bit 4: auto phase versus forced multiphase
// - ctrl bit 3: auto pfm/pwm versus forced pwm
// - ctrl bit 2 resets 1: discharge while disabled
// - ctrl bit 1: enable bit and-ed with pin
// - ctrl bit 0 turns the buck on
// - read-only two-bit part code, 0x00 bits 7:6
// - read-only eight-bit otp version at 0x01
// - write address, register, data; writes auto-increment, reads not
`ifndef PCRM_REGS_SVH
`define PCRM_REGS_SVH

// register addresses
`define PCRM_ADDR_DEVICE_REVISION 8'h00
`define PCRM_ADDR_OTP_VER 8'h01
`define PCRM_ADDR_BUCKA_CTRL 8'h02
`define PCRM_ADDR_PG_CTRL1 8'h15
`define PCRM_ADDR_PG_CTRL2 8'h16
`define PCRM_ADDR_POWER_GOOD_FAULT_STATUS 8'h17
`define PCRM_ADDR_SW_RESET 8'h18
`define PCRM_ADDR_INT_TOP1 8'h19
`define PCRM_ADDR_INT_TOP2 8'h1a
`define PCRM_ADDR_INT_BUCK 8'h1b
`define PCRM_ADDR_INT_LIN 8'h1c
`define PCRM_ADDR_TOP_STAT 8'h1d
`define PCRM_ADDR_BUCK_STAT 8'h1e
`define PCRM_ADDR_LIN_STAT 8'h1f
`define PCRM_ADDR_MASK_TOP1 8'h20
`define PCRM_ADDR_MASK_TOP2 8'h21
`define PCRM_ADDR_MASK_BUCK 8'h22
`define PCRM_ADDR_MASK_LIN 8'h23
`define PCRM_ADDR_LOAD_SEL 8'h24
`define PCRM_ADDR_LOAD_HI 8'h25
`define PCRM_ADDR_LOAD_LO 8'h26

// flop-backed block from power-good control up to the load registers
`define PCRM_MISC_BASE 8'h15
`define PCRM_MISC_COUNT 18

// buck a control fields
`define PCRM_BIT_MPHASE 4
`define PCRM_BIT_FPWM 3
`define PCRM_BIT_RDIS 2
`define PCRM_BIT_PINGATE 1
`define PCRM_BIT_EN 0

// reset values
`define PCRM_BUCKA_CTRL_RST 8'h04
`define PCRM_MISC_RST 8'h00

// serial framing
`define PCRM_BITS_PER_BYTE 4'h8
`define PCRM_ZERO_PAD6 6'h00
`define PCRM_ZERO_PAD4 4'h0
`define PCRM_ZERO_PAD7 7'h00

`endif

// [rtl/pcrm_bank.sv]
// serial-port register bank with buck a control of the pmic
`timescale 1ns/100ps
`default_nettype none
`include "pcrm_regs.svh"

module pcrm_bank
#(
  parameter logic [6:0] DEV_ADDR = 7'h60,    // seven-bit chip address
  parameter logic [1:0] PART_IDENT = 2'h1,   // part code, arbitrary value
  parameter logic [7:0] OTP_VERSION = 8'h3c, // otp version code, arbitrary value
  parameter int MISC_COUNT = `PCRM_MISC_COUNT
)
(
  input wire logic clk_sys,                          // system clock
  input wire logic srst,                             // synchronous reset
  input wire logic scl_in,                           // serial clock level
  input wire logic sda_in,                           // serial data level
  output logic sda_out,                              // data drive level
  output logic sda_oe,                               // high while pulling data low
  input wire logic en_pin,                           // external enable pin
  input wire logic [3:0] power_good_fault_status_in,                // power-good fault flags
  input wire pcrm_pkg::pcrm_byte_t top_stat_in,      // top status
  input wire pcrm_pkg::pcrm_byte_t buck_stat_in,     // buck status
  input wire pcrm_pkg::pcrm_byte_t linear_stat_in,   // linear status
  input wire logic [8:0] load_current_in,            // measured load current
  output logic buck_a_enable,                        // buck a running
  output logic buck_a_forced_pwm,                    // buck a held in pwm
  output logic buck_a_forced_multiphase,             // buck a both phases forced
  output logic buck_a_discharge_enable               // discharge resistor connected
);
  import pcrm_pkg::*;

  // line events
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // byte engine state
  pcrm_state_e state_reg;
  pcrm_state_e state_next;
  pcrm_bitcnt_t bit_cnt_reg;
  pcrm_bitcnt_t bit_cnt_next;
  pcrm_byte_t shift_reg;
  pcrm_byte_t shift_next;
  pcrm_byte_t ptr_reg;
  pcrm_byte_t ptr_next;
  pcrm_byte_t rdata_reg;
  pcrm_byte_t rdata_next;
  logic rw_reg;
  logic rw_next;
  logic oe_reg;
  logic oe_next;
  logic mack_reg;
  logic mack_next;

  // registers
  pcrm_byte_t bucka_ctrl_reg;
  pcrm_byte_t misc_reg [MISC_COUNT];
  logic run_reg;
  logic discharge_reg;

  // decode wires
  logic byte_done;
  logic addr_match;
  logic wr_strobe;
  logic wr_bucka;
  logic wr_misc;
  logic run_next;
  pcrm_byte_t rd_value;

  // only the flop-backed read/write addresses of the misc block take data
  function automatic logic misc_writable(input pcrm_byte_t a);
    misc_writable = (a == `PCRM_ADDR_PG_CTRL1) || (a == `PCRM_ADDR_PG_CTRL2) ||
                    ((a >= `PCRM_ADDR_SW_RESET) && (a <= `PCRM_ADDR_INT_LIN)) ||
                    ((a >= `PCRM_ADDR_MASK_TOP1) && (a <= `PCRM_ADDR_LOAD_SEL));
  endfunction

  // slot of a misc address in the flop array
  function automatic logic [4:0] misc_index(input pcrm_byte_t a);
    pcrm_byte_t d;
    d = a - `PCRM_MISC_BASE;
    misc_index = d[4:0];
  endfunction

  pcrm_line_watch u_watch
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  // eighth clock of a byte has risen and this is its falling edge
  assign byte_done = scl_fall && (bit_cnt_reg == `PCRM_BITS_PER_BYTE);
  assign addr_match = (shift_reg[7:1] == DEV_ADDR);

  // write strobes; read-only addresses decode to nothing
  assign wr_strobe = (state_reg == PCRM_ST_WDATA) && byte_done;
  assign wr_bucka = wr_strobe && (ptr_reg == `PCRM_ADDR_BUCKA_CTRL);
  assign wr_misc = wr_strobe && misc_writable(ptr_reg);

  // read mux; pad bits of the id, fault and load reads are zero, ctrl reads back all eight bits, unmapped addresses read zero
  assign rd_value =
    (ptr_reg == `PCRM_ADDR_DEVICE_REVISION) ? {PART_IDENT, `PCRM_ZERO_PAD6} :
    (ptr_reg == `PCRM_ADDR_OTP_VER) ? OTP_VERSION :
    (ptr_reg == `PCRM_ADDR_BUCKA_CTRL) ? bucka_ctrl_reg :
    (ptr_reg == `PCRM_ADDR_POWER_GOOD_FAULT_STATUS) ? {`PCRM_ZERO_PAD4, power_good_fault_status_in} :
    (ptr_reg == `PCRM_ADDR_TOP_STAT) ? top_stat_in :
    (ptr_reg == `PCRM_ADDR_BUCK_STAT) ? buck_stat_in :
    (ptr_reg == `PCRM_ADDR_LIN_STAT) ? linear_stat_in :
    (ptr_reg == `PCRM_ADDR_LOAD_HI) ? {`PCRM_ZERO_PAD7, load_current_in[8]} :
    (ptr_reg == `PCRM_ADDR_LOAD_LO) ? load_current_in[7:0] :
    misc_writable(ptr_reg) ? misc_reg[misc_index(ptr_reg)] :
    `PCRM_MISC_RST;

  // byte engine next state; start and stop win over any bit activity
  always_comb
  begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    rdata_next = rdata_reg;
    rw_next = rw_reg;
    oe_next = oe_reg;
    mack_next = mack_reg;
    if (start_seen)
    begin
      // also a repeated start: drop any drive and hunt for the address
      state_next = PCRM_ST_ADDR;
      bit_cnt_next = '0;
      oe_next = 1'b0;
    end
    else if (stop_seen)
    begin
      state_next = PCRM_ST_IDLE;
      oe_next = 1'b0;
    end
    else if (scl_rise)
    begin
      // sample on the rising edge, count bits of the byte
      shift_next = {shift_reg[6:0], sda_in};
      if (bit_cnt_reg != `PCRM_BITS_PER_BYTE)
        bit_cnt_next = bit_cnt_reg + 4'h1;
      if (state_reg == PCRM_ST_RDATA_ACK)
        mack_next = ~sda_in;
    end
    else if (scl_fall)
    begin
      case (state_reg)
        PCRM_ST_ADDR:
        begin
          if (byte_done)
          begin
            if (addr_match)
            begin
              state_next = PCRM_ST_ADDR_ACK;
              rw_next = shift_reg[0];
              oe_next = 1'b1;
            end
            else
              state_next = PCRM_ST_IDLE;
          end
        end
        PCRM_ST_ADDR_ACK:
        begin
          bit_cnt_next = '0;
          if (rw_reg)
          begin
            // read starts at the held pointer; first bit goes out now
            state_next = PCRM_ST_RDATA;
            rdata_next = rd_value;
            oe_next = ~rd_value[7];
          end
          else
          begin
            state_next = PCRM_ST_REG;
            oe_next = 1'b0;
          end
        end
        PCRM_ST_REG:
        begin
          if (byte_done)
          begin
            state_next = PCRM_ST_REG_ACK;
            ptr_next = shift_reg;
            oe_next = 1'b1;
          end
        end
        PCRM_ST_REG_ACK:
        begin
          state_next = PCRM_ST_WDATA;
          bit_cnt_next = '0;
          oe_next = 1'b0;
        end
        PCRM_ST_WDATA:
        begin
          // every data byte is acknowledged, even to a read-only address
          if (byte_done)
          begin
            state_next = PCRM_ST_WDATA_ACK;
            oe_next = 1'b1;
          end
        end
        PCRM_ST_WDATA_ACK:
        begin
          // step to the next register for a following data byte
          state_next = PCRM_ST_WDATA;
          bit_cnt_next = '0;
          ptr_next = ptr_reg + 8'h01;
          oe_next = 1'b0;
        end
        PCRM_ST_RDATA:
        begin
          if (byte_done)
          begin
            state_next = PCRM_ST_RDATA_ACK;
            oe_next = 1'b0;
          end
          else
          begin
            rdata_next = {rdata_reg[6:0], 1'b0};
            oe_next = ~rdata_reg[6];
          end
        end
        PCRM_ST_RDATA_ACK:
        begin
          if (mack_reg)
          begin
            // no increment on reads: the same register is sent again
            state_next = PCRM_ST_RDATA;
            bit_cnt_next = '0;
            rdata_next = rd_value;
            oe_next = ~rd_value[7];
          end
          else
            state_next = PCRM_ST_IDLE;
        end
        default:
        begin
          state_next = state_reg;
        end
      endcase
    end
  end

  // byte engine flops
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_reg <= PCRM_ST_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      ptr_reg <= '0;
      rdata_reg <= '0;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      mack_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      rdata_reg <= rdata_next;
      rw_reg <= rw_next;
      oe_reg <= oe_next;
      mack_reg <= mack_next;
    end
  end

  // open-drain data pin: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;

  // buck a control register; discharge bit comes up set
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      bucka_ctrl_reg <= `PCRM_BUCKA_CTRL_RST;
    else if (wr_bucka)
      bucka_ctrl_reg <= shift_reg;
  end

  // power-good, interrupt, mask and load-select storage
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int i = 0; i < MISC_COUNT; i++)
        misc_reg[i] <= `PCRM_MISC_RST;
    end
    else if (wr_misc)
      misc_reg[misc_index(ptr_reg)] <= shift_reg;
  end

  // run decision: enable bit alone, or gated by the pin when selected
  assign run_next = bucka_ctrl_reg[`PCRM_BIT_EN] &
                    (~bucka_ctrl_reg[`PCRM_BIT_PINGATE] | en_pin);

  // registered controls; one cycle behind the register keeps outputs glitch free
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      run_reg <= 1'b0;
      discharge_reg <= 1'b0;
    end
    else
    begin
      run_reg <= run_next;
      discharge_reg <= bucka_ctrl_reg[`PCRM_BIT_RDIS] & ~run_next;
    end
  end

  assign buck_a_enable = run_reg;
  assign buck_a_discharge_enable = discharge_reg;
  assign buck_a_forced_pwm = bucka_ctrl_reg[`PCRM_BIT_FPWM];
  assign buck_a_forced_multiphase = bucka_ctrl_reg[`PCRM_BIT_MPHASE];

endmodule
`default_nettype wire

// [rtl/pcrm_line_watch.sv]
// serial clock and data line watcher: edges, start and stop conditions
`timescale 1ns/100ps
`default_nettype none

module pcrm_line_watch
(
  input wire logic clk_sys,   // system clock
  input wire logic srst,      // synchronous reset
  input wire logic scl_in,    // serial clock level
  input wire logic sda_in,    // serial data level
  output logic scl_rise,      // clock rose this cycle
  output logic scl_fall,      // clock fell this cycle
  output logic start_seen,    // data fell with clock high
  output logic stop_seen      // data rose with clock high
);
  import pcrm_pkg::*;

  logic scl_prev_reg;
  logic sda_prev_reg;

  // previous levels; reset to idle-high so reset never fakes an edge
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
    end
  end

  // edge and condition decode
  assign scl_rise = scl_in & ~scl_prev_reg;
  assign scl_fall = ~scl_in & scl_prev_reg;
  assign start_seen = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
  assign stop_seen = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;

endmodule
`default_nettype wire

// [verif/pcrm_bank_properties.sv]
// concurrent checks on the ports of the pmic register bank
`timescale 1ns/100ps
`default_nettype none
module pcrm_bank_properties
(
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset
  input wire logic scl_in, // serial clock level
  input wire logic sda_in, // resolved data level
  input wire logic sda_oe, // device pulls data low
  input wire logic en_pin, // external enable pin
  input wire logic buck_a_enable, // buck running
  input wire logic buck_a_forced_pwm, // pwm held
  input wire logic buck_a_forced_multiphase, // both phases forced
  input wire logic buck_a_discharge_enable // discharge connected
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // start under a high clock; clock rise within one low phase
  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence s_clock_up;
    ##[1:8] $rose(scl_in);
  endsequence
  // fields move only when a data byte is acknowledged
  a_pwm_on_ack: assert property ($changed(buck_a_forced_pwm) |-> ##[0:2] sda_oe)
    else $error("forced pwm moved outside a write");
  a_phase_on_ack: assert property ($changed(buck_a_forced_multiphase) |-> sda_oe && !scl_in)
    else $error("multiphase moved outside a write");
  // run decision follows a write or a pin change, never by itself
  a_run_has_cause: assert property ($changed(buck_a_enable) |->
    $past(en_pin) != $past(en_pin, 2) || sda_oe)
    else $error("enable moved without cause");
  a_run_no_discharge: assert property (!(buck_a_enable && buck_a_discharge_enable))
    else $error("discharge while running");
  // leaving reset reloads the discharge bit, which shows two cycles after release
  a_discharge_has_cause: assert property ($changed(buck_a_discharge_enable) |->
    $changed(buck_a_enable) || sda_oe || $past(srst, 2))
    else $error("discharge moved without cause");
  // the device moves data only while the clock is low
  a_oe_low_clock: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data moved under high clock");
  a_addr_quiet: assert property (s_start |=> !sda_oe [*8])
    else $error("device drove during address");
  a_ack_held_high: assert property ($rose(sda_oe) |-> sda_oe throughout s_clock_up)
    else $error("drive dropped before clock rise");
endmodule
bind pcrm_bank pcrm_bank_properties u_props (.clk_sys(clk_sys), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe(sda_oe), .en_pin(en_pin), .buck_a_enable(buck_a_enable), .buck_a_forced_pwm(buck_a_forced_pwm),
  .buck_a_forced_multiphase(buck_a_forced_multiphase), .buck_a_discharge_enable(buck_a_discharge_enable));
`default_nettype wire

// [verif/pcrm_host.sv]
// serial bus host model for the register bank
`timescale 1ns/100ps
`default_nettype none
module pcrm_host
(
  input wire logic clk_sys, // bench clock
  output var logic scl, // serial clock, high when idle
  output var logic sda_drv, // data drive, 1 releases the line
  input wire logic sda_line // resolved data level
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one bit; phases of 4 cycles keep well above the 2-cycle minimum
  task automatic bit_io(input logic d, output logic q);
    sda_drv <= d;
    tick(2);
    scl <= 1'b1;
    tick(2);
    q = sda_line;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask
  // also serves as repeated start from a low clock
  task automatic start();
    sda_drv <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda_drv <= 1'b1;
    tick(4);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], q); // msb first
    bit_io(1'b1, q);
    ack = ~q;
  endtask
  // more high keeps the read going, low ends it
  task automatic get(output logic [7:0] b, input logic more);
    logic q;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, q);
      b[i] = q;
    end
    bit_io(~more, q);
  endtask
endmodule
`default_nettype wire

// [verif/test_pcrm_bank.sv]
// self-checking bench for the pmic register bank
`timescale 1ns/100ps
`default_nettype none
module test_pcrm_bank;
  import pcrm_pkg::*;
  localparam logic [6:0] ADDR = 7'h60;
  localparam logic [1:0] PART_ID = 2'h2; // arbitrary value
  localparam logic [7:0] OTP_V = 8'h5d; // arbitrary value
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic en_pin = 1'b0;
  logic [3:0] power_good_fault_status_in = 4'h0;
  pcrm_byte_t top_stat_in = 8'h00;
  pcrm_byte_t buck_stat_in = 8'h00;
  pcrm_byte_t linear_stat_in = 8'h00;
  logic [8:0] load_current_in = 9'h000;
  logic scl, sda_host, sda_oe, sda_out, sda_line, run, pwm, mph, dis, a;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 32'h199c;
  pcrm_byte_t v, ctrl;
  pcrm_byte_t m [5];
  pcrm_byte_t corner [2] = '{8'h03, 8'h1b};
  pcrm_byte_t ro_list [6] = '{8'h17, 8'h1d, 8'h1e, 8'h1f, 8'h25, 8'h26};
  // open-drain line with pull-up: whoever pulls low wins
  assign sda_line = sda_host & ~(sda_oe & ~sda_out);
  initial forever #12.5 clk_sys = ~clk_sys;
  pcrm_bank #(.DEV_ADDR(ADDR), .PART_IDENT(PART_ID), .OTP_VERSION(OTP_V)) uut (.clk_sys(clk_sys), .srst(srst),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .en_pin(en_pin),
    .power_good_fault_status_in(power_good_fault_status_in), .top_stat_in(top_stat_in), .buck_stat_in(buck_stat_in),
    .linear_stat_in(linear_stat_in), .load_current_in(load_current_in), .buck_a_enable(run),
    .buck_a_forced_pwm(pwm), .buck_a_forced_multiphase(mph), .buck_a_discharge_enable(dis));
  pcrm_host host (.clk_sys(clk_sys), .scl(scl), .sda_drv(sda_host), .sda_line(sda_line));
  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // write m[0..n-1] from register ra upward
  task automatic wr(input pcrm_byte_t ra, input int n);
    host.start();
    host.put({ADDR, 1'b0}, a);
    check(a, 1'b1, "addr ack");
    host.put(ra, a);
    for (int i = 0; i < n; i++)
      host.put(m[i], a);
    check(a, 1'b1, "data ack");
    host.stop();
  endtask
  // k reads in one transfer must all give the same register
  task automatic rd(input pcrm_byte_t ra, input int k, output pcrm_byte_t r);
    pcrm_byte_t b;
    host.start();
    host.put({ADDR, 1'b0}, a);
    host.put(ra, a);
    host.start();
    host.put({ADDR, 1'b1}, a);
    for (int i = 0; i < k; i++)
    begin
      host.get(b, i < k - 1);
      if (i == 0)
        r = b;
      check(b, r, "read repeat");
    end
    host.stop();
  endtask
  function automatic logic [3:0] exp_out(input pcrm_byte_t c, input logic pin);
    logic on;
    on = c[0] & (~c[1] | pin);
    return {c[4], c[3], on, c[2] & ~on};
  endfunction
  function automatic pcrm_byte_t exp_ro(input pcrm_byte_t ra);
    case (ra)
      8'h17: return {4'h0, power_good_fault_status_in};
      8'h1d: return top_stat_in;
      8'h1e: return buck_stat_in;
      8'h1f: return linear_stat_in;
      8'h25: return {7'h00, load_current_in[8]};
      default: return load_current_in[7:0];
    endcase
  endfunction
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    power_good_fault_status_in <= 4'($random(seed));
    top_stat_in <= 8'($random(seed)) & 8'h9e;
    buck_stat_in <= 8'($random(seed)) & 8'hdd;
    linear_stat_in <= 8'($random(seed)) & 8'hdd;
    load_current_in <= 9'($random(seed));
    // discharge output is registered: first settled one edge after release
    repeat (2) @(posedge clk_sys);
    check({mph, pwm, run, dis}, exp_out(8'h04, 1'b0), "reset outputs");
    for (int i = 0; i < 5; i++)
      m[i] = 8'($random(seed));
    wr(8'h00, 2);
    rd(8'h00, 1, v);
    check(v[7:6], PART_ID, "part code");
    rd(8'h01, 2, v);
    check(v, OTP_V, "otp code");
    rd(8'h02, 1, v);
    check(v, 8'h04, "ctrl reset");
    host.start();
    host.put({ADDR ^ 7'h01, 1'b0}, a);
    check(a, 1'b0, "foreign address");
    host.stop();
    $display("test identity done");
    wr(8'h20, 5);
    for (int i = 0; i < 5; i++)
    begin
      rd(8'h20 + 8'(i), 1, v);
      check(v, m[i], "burst store");
    end
    // reset and interrupt flag storage, reached only by this burst
    wr(8'h18, 5);
    for (int i = 0; i < 5; i++)
    begin
      rd(8'h18 + 8'(i), 1, v);
      check(v, m[i], "flag store");
    end
    wr(8'h15, 3);
    wr(8'h1d, 3);
    wr(8'h25, 2);
    rd(8'h16, 1, v);
    check(v, m[1], "burst into read-only");
    foreach (ro_list[i])
    begin
      rd(ro_list[i], 1, v);
      check(v, exp_ro(ro_list[i]), "read-only kept");
    end
    rd(8'h30, 1, v);
    check(v, 8'h00, "unmapped read");
    $display("test burst done");
    for (int i = 0; i < 10; i++)
    begin
      ctrl = (i < 2) ? corner[i] : 8'($random(seed)) & 8'h1f;
      en_pin <= (i == 0) ? 1'b0 : 1'($random(seed));
      m[0] = ctrl;
      wr(8'h02, 1);
      rd(8'h02, 1, v);
      check(v, ctrl, "ctrl readback");
      check({mph, pwm, run, dis}, exp_out(ctrl, en_pin), "buck fields");
      en_pin <= ~en_pin;
      repeat (3) @(posedge clk_sys);
      check({mph, pwm, run, dis}, exp_out(ctrl, en_pin), "pin gating");
    end
    $display("test control done");
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check({mph, pwm, run, dis}, exp_out(8'h04, en_pin), "second reset");
    rd(8'h02, 1, v);
    check(v, 8'h04, "ctrl after reset");
    $display("test reset done");
    close_out();
  end
endmodule
`default_nettype wire
